// File: cbd_defs.svh
// Constants of the bus-cycle decoder: vectors, opcodes, reset values
// Notes on behaviour
// (RQ1) A free cycle needs no bus, lasts one clock and shows as a read.
// (RQ2) A program fetch reads the location after the previously fetched byte.
// (RQ3) An operand read moves one 8-bit byte from memory into the core.
// (RQ4) An operand write moves one 8-bit byte from the core to memory.
// (RQ5) A stack push writes exactly one byte to the stack.
// (RQ6) A stack pop reads exactly one byte back from the stack.
// (RQ7) Vector fetch reads the handler address from the top page, high byte first.
// (RQ8) Indexed mode with 8-bit offset and post increment increments the index after the access.
// (RQ9) Indexed mode with no offset and post increment increments the index after the access.
// (RQ10) Stack mode with 16-bit offset adds the 16-bit offset to the stack pointer for the address.
// (RQ11) Wait clears the interrupt mask, then halts until an interrupt; two cycles.
// (RQ12) Accumulator-to-flags transfer loads the flags from the accumulator in one cycle.
// (RQ13) A lookup table maps each opcode to an addressing mode and an operation.
`ifndef CBD_DEFS_SVH
`define CBD_DEFS_SVH

// ****************************************
// Vectors and reset values
// ****************************************
`define CBD_VEC_RESET      16'hFFFE
`define CBD_VEC_TRAP       16'hFFFC
`define CBD_VEC_IRQ        16'hFFFA
`define CBD_SP_RESET       16'h00FF
`define CBD_HX_RESET       16'h0000
`define CBD_FLAGS_RESET    8'h08
`define CBD_FLAGS_IMASK    3
`define CBD_ZERO_PAGE      8'h00
`define CBD_INTR_PUSHES    3'h5

// ****************************************
// Opcodes
// ****************************************
`define CBD_OPC_PAGE2      8'h9E
`define CBD_OPC_TRAP       8'h83
`define CBD_OPC_TAP        8'h84
`define CBD_OPC_TPA        8'h85
`define CBD_OPC_PULA       8'h86
`define CBD_OPC_PSHA       8'h87
`define CBD_OPC_WAIT       8'h8F
`define CBD_OPC_CBEQ_IX1P  8'h61
`define CBD_OPC_CBEQ_IXP   8'h71
`define CBD_LO_LOAD        4'h6
`define CBD_LO_STORE       4'h7
`define CBD_HI_IMM         4'hA
`define CBD_HI_DIR         4'hB
`define CBD_HI_EXT         4'hC
`define CBD_HI_IX2         4'hD
`define CBD_HI_IX1         4'hE
`define CBD_HI_IX          4'hF

`endif

// File: cbd_pkg.sv
// Types of the bus-cycle decoder
package cbd_pkg;

  typedef enum {
    ST_VHI, ST_VLO, ST_FETCH, ST_ADR1, ST_ADR2, ST_EXEC, ST_REL,
    ST_PUSH, ST_POP, ST_FREE, ST_HALT
  } state_t;

  typedef enum logic [3:0] {
    M_INH, M_IMM, M_DIR, M_EXT, M_IX, M_IX1, M_IX2, M_IXP, M_IX1P, M_SP1, M_SP2
  } mode_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_LDA, OP_STA, OP_CBEQ, OP_TAP, OP_TPA, OP_WAIT, OP_TRAP, OP_PSHA, OP_PULA
  } op_t;

  typedef enum logic [2:0] {
    CK_IDLE, CK_FREE, CK_PFETCH, CK_READ, CK_WRITE, CK_PUSH, CK_POP, CK_VECTOR
  } kind_t;

  typedef struct packed {
    mode_t mode;
    op_t   op;
  } dec_t;

endpackage : cbd_pkg

// File: cbd_decode.sv
// Instruction decode and bus-cycle sequencer of the 8-bit core
`timescale 1ns/1ps
`include "cbd_defs.svh"

module cbd_decode (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // System bus
  output logic      [15:0] BUS_ADDR,
  output logic             BUS_RD,
  output logic             BUS_WR,
  output logic      [7:0]  BUS_WDATA,
  input  wire logic [7:0]  BUS_RDATA,
  output logic      [2:0]  CYCLE_KIND,
  // Interrupt and status
  input  wire logic        INT_REQ,
  output logic             HALTED,
  output logic      [7:0]  ACC_OUT,
  output logic      [7:0]  FLAGS_OUT
);

  // ****************************************
  // Opcode lookup table
  // ****************************************
  function automatic cbd_pkg::dec_t cbd_lookup(input logic pg2, input logic [7:0] opc);
    cbd_pkg::dec_t r;
    r.mode = cbd_pkg::M_INH;
    r.op   = cbd_pkg::OP_NOP;
    if (opc[3:0] == `CBD_LO_LOAD || opc[3:0] == `CBD_LO_STORE) begin
      r.op = (opc[3:0] == `CBD_LO_LOAD) ? cbd_pkg::OP_LDA : cbd_pkg::OP_STA;
      if (pg2) begin
        if (opc[7:4] == `CBD_HI_IX2)      r.mode = cbd_pkg::M_SP2;
        else if (opc[7:4] == `CBD_HI_IX1) r.mode = cbd_pkg::M_SP1;
        else                              r.op = cbd_pkg::OP_NOP;
      end else begin
        case (opc[7:4])
          `CBD_HI_IMM: r.mode = cbd_pkg::M_IMM;
          `CBD_HI_DIR: r.mode = cbd_pkg::M_DIR;
          `CBD_HI_EXT: r.mode = cbd_pkg::M_EXT;
          `CBD_HI_IX2: r.mode = cbd_pkg::M_IX2;
          `CBD_HI_IX1: r.mode = cbd_pkg::M_IX1;
          `CBD_HI_IX:  r.mode = cbd_pkg::M_IX;
          default:     r.op   = cbd_pkg::OP_NOP;
        endcase
        if (opc == `CBD_OPC_PSHA)      r.op = cbd_pkg::OP_PSHA;
        else if (opc == `CBD_OPC_PULA) r.op = cbd_pkg::OP_PULA;
        else if (r.mode == cbd_pkg::M_IMM && r.op == cbd_pkg::OP_STA) begin
          // Unsupported: one-byte NOP, so no operand byte is taken
          r.op   = cbd_pkg::OP_NOP;
          r.mode = cbd_pkg::M_INH;
        end
      end
    end else if (!pg2) begin
      case (opc)
        `CBD_OPC_TAP:       r.op = cbd_pkg::OP_TAP;
        `CBD_OPC_TPA:       r.op = cbd_pkg::OP_TPA;
        `CBD_OPC_WAIT:      r.op = cbd_pkg::OP_WAIT;
        `CBD_OPC_TRAP:      r.op = cbd_pkg::OP_TRAP;
        `CBD_OPC_CBEQ_IX1P: begin
          r.op   = cbd_pkg::OP_CBEQ;
          r.mode = cbd_pkg::M_IX1P;
        end
        `CBD_OPC_CBEQ_IXP: begin
          r.op   = cbd_pkg::OP_CBEQ;
          r.mode = cbd_pkg::M_IXP;
        end
        default:            r.op = cbd_pkg::OP_NOP;
      endcase
    end
    return r;
  endfunction : cbd_lookup

  // ****************************************
  // Sequencer state
  // ****************************************
  cbd_pkg::state_t state_q, state_d;
  cbd_pkg::mode_t  mode_q,  mode_d;
  cbd_pkg::op_t    op_q,    op_d;
  cbd_pkg::dec_t   dec;
  logic [15:0]     pc_q,    pc_d;
  logic [15:0]     sp_q,    sp_d;
  logic [15:0]     hx_q,    hx_d;
  logic [15:0]     ea_q,    ea_d;
  logic [15:0]     vec_q,   vec_d;
  logic [7:0]      a_q,     a_d;
  logic [7:0]      flags_q, flags_d;
  logic [7:0]      hi_q,    hi_d;
  logic [2:0]      cnt_q,   cnt_d;
  logic            pg2_q,   pg2_d;
  logic            intr_q,  intr_d;
  logic            eq_q,    eq_d;

  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    op_d    = op_q;
    pc_d    = pc_q;
    sp_d    = sp_q;
    hx_d    = hx_q;
    ea_d    = ea_q;
    vec_d   = vec_q;
    a_d     = a_q;
    flags_d = flags_q;
    hi_d    = hi_q;
    cnt_d   = cnt_q;
    pg2_d   = pg2_q;
    intr_d  = intr_q;
    eq_d    = eq_q;
    dec     = cbd_lookup(pg2_q, BUS_RDATA);                              // RQ13
    unique case (state_q)
      cbd_pkg::ST_VHI: begin
        pc_d[15:8] = BUS_RDATA;                                          // RQ7
        state_d    = cbd_pkg::ST_VLO;
      end
      cbd_pkg::ST_VLO: begin
        pc_d[7:0] = BUS_RDATA;                                           // RQ7
        state_d   = cbd_pkg::ST_FETCH;
      end
      cbd_pkg::ST_FETCH: begin
        if (INT_REQ && !flags_q[`CBD_FLAGS_IMASK] && !pg2_q) begin
          intr_d  = 1'b1;
          vec_d   = `CBD_VEC_IRQ;
          cnt_d   = `CBD_INTR_PUSHES;
          state_d = cbd_pkg::ST_PUSH;
        end else if (BUS_RDATA == `CBD_OPC_PAGE2 && !pg2_q) begin
          pc_d  = pc_q + 16'h0001;                                       // RQ2
          pg2_d = 1'b1;
        end else begin
          pc_d   = pc_q + 16'h0001;                                      // RQ2
          pg2_d  = 1'b0;
          mode_d = dec.mode;
          op_d   = dec.op;
          ea_d   = hx_q;
          unique case (dec.mode)
            cbd_pkg::M_INH: begin
              state_d = cbd_pkg::ST_FETCH;
              unique case (dec.op)
                cbd_pkg::OP_TAP:  flags_d = a_q;                         // RQ12
                cbd_pkg::OP_TPA:  a_d = flags_q;
                cbd_pkg::OP_WAIT: begin
                  flags_d[`CBD_FLAGS_IMASK] = 1'b0;                      // RQ11
                  state_d = cbd_pkg::ST_FREE;
                end
                cbd_pkg::OP_TRAP: begin
                  intr_d  = 1'b1;
                  vec_d   = `CBD_VEC_TRAP;
                  cnt_d   = `CBD_INTR_PUSHES;
                  state_d = cbd_pkg::ST_PUSH;
                end
                cbd_pkg::OP_PSHA: begin
                  intr_d  = 1'b0;
                  cnt_d   = 3'h1;
                  state_d = cbd_pkg::ST_PUSH;
                end
                cbd_pkg::OP_PULA: state_d = cbd_pkg::ST_FREE;
                default:          state_d = cbd_pkg::ST_FETCH;
              endcase
            end
            cbd_pkg::M_IX, cbd_pkg::M_IXP: state_d = cbd_pkg::ST_EXEC;
            default:                       state_d = cbd_pkg::ST_ADR1;
          endcase
        end
      end
      cbd_pkg::ST_ADR1: begin
        pc_d    = pc_q + 16'h0001;                                       // RQ2
        hi_d    = BUS_RDATA;
        state_d = cbd_pkg::ST_EXEC;
        unique case (mode_q)
          cbd_pkg::M_IMM: begin
            a_d     = BUS_RDATA;
            state_d = cbd_pkg::ST_FETCH;
          end
          cbd_pkg::M_DIR:                  ea_d = {`CBD_ZERO_PAGE, BUS_RDATA};
          cbd_pkg::M_IX1, cbd_pkg::M_IX1P: ea_d = hx_q + {8'h00, BUS_RDATA};
          cbd_pkg::M_SP1:                  ea_d = sp_q + {8'h00, BUS_RDATA};
          default:                         state_d = cbd_pkg::ST_ADR2;
        endcase
      end
      cbd_pkg::ST_ADR2: begin
        pc_d    = pc_q + 16'h0001;                                       // RQ2
        state_d = cbd_pkg::ST_EXEC;
        unique case (mode_q)
          cbd_pkg::M_IX2: ea_d = hx_q + {hi_q, BUS_RDATA};
          cbd_pkg::M_SP2: ea_d = sp_q + {hi_q, BUS_RDATA};               // RQ10
          default:        ea_d = {hi_q, BUS_RDATA};
        endcase
      end
      cbd_pkg::ST_EXEC: begin
        state_d = cbd_pkg::ST_FETCH;
        if (op_q == cbd_pkg::OP_LDA) a_d = BUS_RDATA;                    // RQ3
        if (op_q == cbd_pkg::OP_CBEQ) begin
          eq_d    = (BUS_RDATA == a_q);                                  // RQ3
          state_d = cbd_pkg::ST_REL;
        end
        if (mode_q == cbd_pkg::M_IXP || mode_q == cbd_pkg::M_IX1P)
          hx_d = hx_q + 16'h0001;                                        // RQ8 RQ9
      end
      cbd_pkg::ST_REL: begin
        pc_d    = eq_q ? pc_q + 16'h0001 + {{8{BUS_RDATA[7]}}, BUS_RDATA}
                       : pc_q + 16'h0001;
        state_d = cbd_pkg::ST_FETCH;
      end
      cbd_pkg::ST_PUSH: begin
        sp_d  = sp_q - 16'h0001;                                         // RQ5
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          if (intr_q) begin
            flags_d[`CBD_FLAGS_IMASK] = 1'b1;
            state_d = cbd_pkg::ST_VHI;
          end else begin
            state_d = cbd_pkg::ST_FETCH;
          end
          intr_d = 1'b0;
        end
      end
      cbd_pkg::ST_FREE: begin
        if (op_q == cbd_pkg::OP_WAIT) begin
          state_d = cbd_pkg::ST_HALT;                                    // RQ11
        end else begin
          sp_d    = sp_q + 16'h0001;
          state_d = cbd_pkg::ST_POP;
        end
      end
      cbd_pkg::ST_POP: begin
        a_d     = BUS_RDATA;                                             // RQ6
        state_d = cbd_pkg::ST_FETCH;
      end
      cbd_pkg::ST_HALT: begin
        if (INT_REQ) begin                                               // RQ11
          intr_d  = 1'b1;
          vec_d   = `CBD_VEC_IRQ;
          cnt_d   = `CBD_INTR_PUSHES;
          state_d = cbd_pkg::ST_PUSH;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_q <= cbd_pkg::ST_VHI;
      mode_q  <= cbd_pkg::M_INH;
      op_q    <= cbd_pkg::OP_NOP;
      pc_q    <= 16'h0000;
      sp_q    <= `CBD_SP_RESET;
      hx_q    <= `CBD_HX_RESET;
      ea_q    <= 16'h0000;
      vec_q   <= `CBD_VEC_RESET;
      a_q     <= 8'h00;
      flags_q <= `CBD_FLAGS_RESET;
      hi_q    <= 8'h00;
      cnt_q   <= 3'h0;
      pg2_q   <= 1'b0;
      intr_q  <= 1'b0;
      eq_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q  <= mode_d;
      op_q    <= op_d;
      pc_q    <= pc_d;
      sp_q    <= sp_d;
      hx_q    <= hx_d;
      ea_q    <= ea_d;
      vec_q   <= vec_d;
      a_q     <= a_d;
      flags_q <= flags_d;
      hi_q    <= hi_d;
      cnt_q   <= cnt_d;
      pg2_q   <= pg2_d;
      intr_q  <= intr_d;
      eq_q    <= eq_d;
    end
  end

  // ****************************************
  // Bus cycle registers
  // ****************************************
  cbd_pkg::kind_t kind_q, kind_d;
  logic [15:0]    addr_q, addr_d;
  logic           rd_q,   rd_d;
  logic           wr_q,   wr_d;
  logic [7:0]     wd_q,   wd_d;
  logic           halt_q, halt_d;

  // Drive the cycle that the sequencer enters next
  always_comb begin
    kind_d = cbd_pkg::CK_IDLE;
    addr_d = pc_d;
    rd_d   = 1'b0;
    wr_d   = 1'b0;
    wd_d   = 8'h00;
    halt_d = (state_d == cbd_pkg::ST_HALT);                              // RQ11
    unique case (state_d)
      cbd_pkg::ST_VHI, cbd_pkg::ST_VLO: begin
        kind_d = cbd_pkg::CK_VECTOR;                                     // RQ7
        addr_d = (state_d == cbd_pkg::ST_VHI) ? vec_d : vec_d + 16'h0001;
        rd_d   = 1'b1;
      end
      cbd_pkg::ST_FETCH, cbd_pkg::ST_ADR1, cbd_pkg::ST_ADR2, cbd_pkg::ST_REL: begin
        kind_d = cbd_pkg::CK_PFETCH;                                     // RQ2
        rd_d   = 1'b1;
      end
      cbd_pkg::ST_FREE: begin
        kind_d = cbd_pkg::CK_FREE;                                       // RQ1
        rd_d   = 1'b1;
      end
      cbd_pkg::ST_EXEC: begin
        addr_d = ea_d;
        if (op_d == cbd_pkg::OP_STA) begin
          kind_d = cbd_pkg::CK_WRITE;                                    // RQ4
          wr_d   = 1'b1;
          wd_d   = a_d;
        end else begin
          kind_d = cbd_pkg::CK_READ;                                     // RQ3
          rd_d   = 1'b1;
        end
      end
      cbd_pkg::ST_PUSH: begin
        kind_d = cbd_pkg::CK_PUSH;                                       // RQ5
        addr_d = sp_d;
        wr_d   = 1'b1;
        wd_d   = a_d;
        if (intr_d) begin
          unique case (cnt_d)
            3'h5:    wd_d = pc_d[7:0];
            3'h4:    wd_d = pc_d[15:8];
            3'h3:    wd_d = hx_d[7:0];
            3'h2:    wd_d = a_d;
            default: wd_d = flags_d;
          endcase
        end
      end
      cbd_pkg::ST_POP: begin
        kind_d = cbd_pkg::CK_POP;                                        // RQ6
        addr_d = sp_d;
        rd_d   = 1'b1;
      end
      cbd_pkg::ST_HALT: kind_d = cbd_pkg::CK_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      kind_q <= cbd_pkg::CK_VECTOR;
      addr_q <= `CBD_VEC_RESET;
      rd_q   <= 1'b1;
      wr_q   <= 1'b0;
      wd_q   <= 8'h00;
      halt_q <= 1'b0;
    end else begin
      kind_q <= kind_d;
      addr_q <= addr_d;
      rd_q   <= rd_d;
      wr_q   <= wr_d;
      wd_q   <= wd_d;
      halt_q <= halt_d;
    end
  end

  assign BUS_ADDR   = addr_q;
  assign BUS_RD     = rd_q;
  assign BUS_WR     = wr_q;
  assign BUS_WDATA  = wd_q;
  assign CYCLE_KIND = kind_q;
  assign HALTED     = halt_q;
  assign ACC_OUT    = a_q;
  assign FLAGS_OUT  = flags_q;

endmodule : cbd_decode

// File: cbd_decode_sva.sv
// Concurrent checks on the bus cycles of the decoder
`timescale 1ns/1ps

module cbd_decode_sva (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // System bus
  input wire logic [15:0] BUS_ADDR,
  input wire logic        BUS_RD,
  input wire logic        BUS_WR,
  input wire logic [7:0]  BUS_WDATA,
  input wire logic [7:0]  BUS_RDATA,
  input wire logic [2:0]  CYCLE_KIND,
  // Interrupt and status
  input wire logic        INT_REQ,
  input wire logic        HALTED,
  input wire logic [7:0]  ACC_OUT,
  input wire logic [7:0]  FLAGS_OUT
);
  default clocking cb_main @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  // ****************************************
  // Sequences
  // ****************************************
  sequence s_wait_fetch;
    CYCLE_KIND == 3'h2 && BUS_RDATA == 8'h8F;
  endsequence
  sequence s_halt_entry;
    CYCLE_KIND == 3'h1 ##1 (HALTED && CYCLE_KIND == 3'h0 && !FLAGS_OUT[3]);
  endsequence
  sequence s_wake;
    (CYCLE_KIND == 3'h5) [*5] ##1 (CYCLE_KIND == 3'h7 && BUS_ADDR == 16'hFFFA);
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  a_free_read_once: assert property (CYCLE_KIND == 3'h1 |-> BUS_RD && !BUS_WR
    ##1 CYCLE_KIND != 3'h1) else $error("free cycle not a single read");
  a_fetch_next_addr: assert property ((CYCLE_KIND != 3'h3 ##1 CYCLE_KIND == 3'h2
    ##1 CYCLE_KIND == 3'h2) |-> BUS_ADDR == $past(BUS_ADDR) + 16'h0001)
    else $error("program fetch not sequential");
  a_read_operand: assert property (CYCLE_KIND == 3'h3 |-> BUS_RD && !BUS_WR)
    else $error("operand read not a read");
  a_write_operand: assert property (CYCLE_KIND == 3'h4 |-> BUS_WR && !BUS_RD
    && BUS_WDATA == ACC_OUT) else $error("operand write wrong");
  a_push_one_byte: assert property (CYCLE_KIND == 3'h5 |-> BUS_WR && !BUS_RD
    ##1 (CYCLE_KIND != 3'h5 || BUS_ADDR == $past(BUS_ADDR) - 16'h0001))
    else $error("push not one byte per cycle");
  a_pop_one_byte: assert property (CYCLE_KIND == 3'h6 |-> BUS_RD && !BUS_WR
    ##1 ACC_OUT == $past(BUS_RDATA)) else $error("pop byte not taken");
  a_vector_pair: assert property (CYCLE_KIND == 3'h7 && !BUS_ADDR[0]
    |-> BUS_ADDR[15:8] == 8'hFF ##1 (CYCLE_KIND == 3'h7
    && BUS_ADDR == $past(BUS_ADDR) + 16'h0001)) else $error("vector order wrong");
  a_tap_load: assert property (CYCLE_KIND == 3'h2 && BUS_RDATA == 8'h84
    |=> FLAGS_OUT == $past(ACC_OUT)) else $error("flags not loaded from acc");
  a_wait_halt: assert property (s_wait_fetch |=> s_halt_entry)
    else $error("wait did not halt");
  a_halt_quiet: assert property (HALTED |-> !BUS_RD && !BUS_WR && CYCLE_KIND == 3'h0)
    else $error("bus active while halted");
  a_wake_push: assert property (HALTED && INT_REQ |=> s_wake)
    else $error("wake sequence wrong");
endmodule : cbd_decode_sva

bind cbd_decode cbd_decode_sva chk_u (
  .REF_CLK    (REF_CLK),
  .SYS_RST    (SYS_RST),
  .BUS_ADDR   (BUS_ADDR),
  .BUS_RD     (BUS_RD),
  .BUS_WR     (BUS_WR),
  .BUS_WDATA  (BUS_WDATA),
  .BUS_RDATA  (BUS_RDATA),
  .CYCLE_KIND (CYCLE_KIND),
  .INT_REQ    (INT_REQ),
  .HALTED     (HALTED),
  .ACC_OUT    (ACC_OUT),
  .FLAGS_OUT  (FLAGS_OUT)
);

// File: cbd_mem_model.sv
// Behavioural memory on the far side of the system bus
`timescale 1ns/1ps

module cbd_mem_model (
  // Bus side
  input  wire logic        clk,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;

  // Zero-wait answer; an unread bus shows the inverse of the last byte
  always_comb rdata = rd ? mem[addr] : ~last_q;

  always @(posedge clk) begin
    if (rd) begin
      last_q <= mem[addr];
    end
    if (wr) begin
      mem[addr] <= wdata;
    end
  end
endmodule : cbd_mem_model

// File: cbd_decode_tb_top.sv
// Self-checking testbench of the bus-cycle decoder
`timescale 1ns/1ps

module cbd_decode_tb_top;
  logic        ref_clk;
  logic        sys_rst;
  logic        int_req = 1'b0;
  logic [15:0] bus_addr;
  logic        bus_rd;
  logic        bus_wr;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;
  logic [2:0]  cycle_kind;
  logic        halted;
  logic [7:0]  acc_out;
  logic [7:0]  flags_out;
  int          failures = 0;
  int          checks = 0;
  // Program from 0100: LDA#, TAP, STA dir/ext, PSHA, PULA, SP1, SP2, ,X, CBEQ X+ / ff,X+, WAIT
  logic [7:0]  prog [$] = '{8'hA6, 8'h5A, 8'h84, 8'hB7, 8'h40, 8'hC7, 8'h12, 8'h34, 8'h87,
    8'h86, 8'h9E, 8'hE6, 8'h01, 8'h9E, 8'hD7, 8'h10, 8'h00, 8'hF7, 8'h71, 8'h02, 8'h9D,
    8'h9D, 8'h61, 8'h10, 8'h01, 8'h8F};
  // Expected cycles: kind, address, write data, pad
  logic [31:0] rows [$] = '{32'h7FFF_E000, 32'h7FFF_F000, 32'h2010_0000, 32'h2010_1000,
    32'h2010_2000, 32'h2010_3000, 32'h2010_4000, 32'h4004_05A0, 32'h2010_5000, 32'h2010_6000,
    32'h2010_7000, 32'h4123_45A0, 32'h2010_8000, 32'h500F_F5A0, 32'h2010_9000, 32'h1010_A000,
    32'h600F_F000, 32'h2010_A000, 32'h2010_B000, 32'h2010_C000, 32'h3010_0000, 32'h2010_D000,
    32'h2010_E000, 32'h2010_F000, 32'h2011_0000, 32'h410F_FA60, 32'h2011_1000, 32'h4000_0A60,
    32'h2011_2000, 32'h3000_0000, 32'h2011_3000, 32'h2011_6000, 32'h2011_7000, 32'h3001_1000,
    32'h2011_8000, 32'h2011_9000, 32'h1011_A000, 32'h0000_0000, 32'h0000_0000, 32'h500F_F1A0,
    32'h500F_E010, 32'h500F_D020, 32'h500F_CA60, 32'h500F_B520, 32'h7FFF_A000, 32'h7FFF_B000,
    32'h2020_0000, 32'h2020_1000};

  cbd_decode dut_u (
    .REF_CLK    (ref_clk),
    .SYS_RST    (sys_rst),
    .BUS_ADDR   (bus_addr),
    .BUS_RD     (bus_rd),
    .BUS_WR     (bus_wr),
    .BUS_WDATA  (bus_wdata),
    .BUS_RDATA  (bus_rdata),
    .CYCLE_KIND (cycle_kind),
    .INT_REQ    (int_req),
    .HALTED     (halted),
    .ACC_OUT    (acc_out),
    .FLAGS_OUT  (flags_out)
  );

  cbd_mem_model mem_u (
    .clk   (ref_clk),
    .rd    (bus_rd),
    .wr    (bus_wr),
    .addr  (bus_addr),
    .wdata (bus_wdata),
    .rdata (bus_rdata)
  );

  // ****************************************
  // Clock, interrupt source, watchdog
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Interrupt arrives one cycle after the core halts
  always @(posedge ref_clk) int_req <= (halted === 1'b1);

  initial begin
    repeat (2000) @(posedge ref_clk);
    failures++;
    complete_run();
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask : chk

  task automatic check_row(input int i);
    logic [3:0] k;
    k = rows[i][31:28];
    @(negedge ref_clk);
    chk("cycle_kind", 16'(k), 16'(cycle_kind));
    if (k != 4'h0) chk("bus_addr", rows[i][27:12], bus_addr);
    chk("bus_wdata", 16'(rows[i][11:4]), 16'(bus_wdata));
    chk("bus_rd", 16'(k inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7}), 16'(bus_rd));
    chk("bus_wr", 16'(k inside {4'h4, 4'h5}), 16'(bus_wr));
    chk("halted", 16'(k == 4'h0), 16'(halted));
  endtask : check_row

  task automatic check_reset;
    @(negedge ref_clk);
    chk("reset_addr", 16'hFFFE, bus_addr);
    chk("reset_kind", 16'h0007, 16'(cycle_kind));
    chk("reset_acc", 16'h0000, 16'(acc_out));
    chk("reset_flags", 16'h0008, 16'(flags_out));
    chk("reset_halted", 16'h0000, 16'(halted));
  endtask : check_reset

  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    foreach (mem_u.mem[a]) mem_u.mem[a] = 8'h00;
    foreach (prog[i]) mem_u.mem[16'h0100 + 16'(i)] = prog[i];
    mem_u.mem[16'hFFFE] = 8'h01;
    mem_u.mem[16'hFFFA] = 8'h02;
    @(posedge ref_clk);
    check_reset();
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) check_row(i);
    chk("acc_out", 16'h00A6, 16'(acc_out));
    // Reset again in mid-run, then restart from the vector
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    check_reset();
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) check_row(i);
    complete_run();
  end
endmodule : cbd_decode_tb_top
